// >>> spe_consts.vh
// constants for the serial eeprom command and protection logic
`ifndef SPE_CONSTS_VH
`define SPE_CONSTS_VH
`define SPE_OP_SET_LATCH   8'h06
`define SPE_OP_CLR_LATCH   8'h04
`define SPE_OP_STAT_READ   8'h05
`define SPE_OP_STAT_WRITE  8'h01
`define SPE_OP_READ_LOW    3'h3
`define SPE_OP_WRITE_LOW   3'h2
`define SPE_OP_HIGH_NIB    4'h0
`define SPE_OP_A8_BIT      3
`define SPE_STAT_TOP       4'hf
`define SPE_STAT_BUSY      8'hff
`define SPE_BP_NONE        2'h0
`define SPE_BP_QUARTER     2'h1
`define SPE_BP_HALF        2'h2
`define SPE_BP_FULL        2'h3
`define SPE_PAGE_BYTES     16
`define SPE_WRITE_TIME_US  5000
`define SPE_CLK_MHZ        250
`define SPE_BIT_LAST       3'h7
`define SPE_SYNC_IDLE      5'h17
`endif

// >>> spe_mem.v
// byte-wide array memory with registered read data
`timescale 1ns/1ns
module spe_mem #(
    parameter AW = 9
) (
    // clock
    input  wire          core_clk,
    // write port
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [7:0]    wr_data,
    // read port
    input  wire [AW-1:0] rd_addr,
    output reg  [7:0]    rd_data
);
    reg [7:0] mem [0:(1<<AW)-1];

    always @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// >>> spe_core.v
// spi eeprom command decode, status word, protection and write cycle
// How it works
// - status bit 0 is busy during write
// - set/clear latch commands drive write latch
// - status word: 1111, protect bits, latch, busy
// - protect bits held, changed by status write
// - protect bits select none/quarter/half/all
// - latch cleared after power-up
// - writes need latch and unprotected address
// - set latch only when chip select closes
// - write: opcode, address, data; a8 in opcode
// - programming starts at chip-select rising edge
// - busy: only status read accepted
// - page of 16 bytes, low address wraps
// - write cycle start clears the latch
// - status write changes bits 2,3 only
// - write guard low blocks all writes
// - guard fall while selected aborts status write
// - read: opcode, address, data follows immediately
// - read address increments and wraps around
// - status readable anytime, ffh while busy
// - hold floats so and ignores si
// - invalid opcode ignored, so stays floating
// - standby until chip select goes low
// - opcode decode table
// - sample rising sck, shift falling sck
// - deselected: so floating, standby
`timescale 1ns/1ns
`include "spe_consts.vh"
module spe_core #(
    parameter AW       = 9,
    parameter WC_TIME  = `SPE_WRITE_TIME_US * `SPE_CLK_MHZ
) (
    // clock and reset
    input  wire core_clk,
    input  wire arst_n,
    // spi pins
    input  wire cs_n,
    input  wire sck,
    input  wire si,
    input  wire hold_n,
    input  wire wp_n,
    output reg  so,
    output reg  so_oe,
    // state
    output wire busy
);
    localparam PB = 4;
    localparam ST_IDLE = 6'h01;
    localparam ST_OP   = 6'h02;
    localparam ST_ADDR = 6'h04;
    localparam ST_WDAT = 6'h08;
    localparam ST_RDAT = 6'h10;
    localparam ST_SKIP = 6'h20;

    // two-flop synchronisers
    reg [4:0] sync1;
    reg [4:0] sync2;
    reg       sck_d;
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            // sck rests low here so no false edge follows reset
            sync1 <= `SPE_SYNC_IDLE;
            sync2 <= `SPE_SYNC_IDLE;
            sck_d <= 1'b0;
        end else begin
            sync1 <= {cs_n, sck, si, hold_n, wp_n};
            sync2 <= sync1;
            sck_d <= sync2[3];
        end
    end
    wire cs_s   = sync2[4];
    wire sck_s  = sync2[3];
    wire si_s   = sync2[2];
    wire hold_s = sync2[1];
    wire wp_s   = sync2[0];
    reg  cs_d;
    reg  hold_d;
    reg  paused;
    wire sck_rise = sck_s & ~sck_d & ~paused;
    wire sck_fall = ~sck_s & sck_d & ~paused;
    wire cs_rise  = cs_s & ~cs_d;
    wire sel      = ~cs_s;

    // hold: paused after hold low with sck low, resumes likewise
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            paused <= 1'b0;
            hold_d <= 1'b1;
            cs_d   <= 1'b1;
        end else begin
            cs_d   <= cs_s;
            hold_d <= hold_s;
            if (!sel) begin
                paused <= 1'b0;
            end else if (!sck_s && hold_s != hold_d) begin
                paused <= ~hold_s;
            end
        end
    end

    reg  [5:0]    state;
    reg  [2:0]    bitc;
    reg  [7:0]    shin;
    reg  [7:0]    opcode;
    reg  [AW-1:0] addr;
    reg  [7:0]    shout;
    reg           out_en;
    reg           wlatch;
    reg  [1:0]    bp;
    reg  [1:0]    bp_pend;
    reg           st_pend;
    reg           latch_pend;
    reg  [7:0]    pbuf [0:`SPE_PAGE_BYTES-1];
    reg  [`SPE_PAGE_BYTES-1:0] pvalid;
    reg  [AW-1:0] page_base;
    reg           prog;
    reg  [PB-1:0] pidx;
    reg  [31:0]   wtimer;
    wire [7:0]    mem_rd;
    wire [7:0]    byte_in = {shin[6:0], si_s};
    wire          last_bit = (bitc == `SPE_BIT_LAST);

    assign busy = (wtimer != 32'h0) | prog;

    // protect decode over the top address bits
    function prot;
        input [1:0]    b;
        input [AW-1:0] a;
        begin
            case (b)
                `SPE_BP_QUARTER: prot = &a[AW-1:AW-2];
                `SPE_BP_HALF:    prot = a[AW-1];
                `SPE_BP_FULL:    prot = 1'b1;
                default:         prot = 1'b0;
            endcase
        end
    endfunction

    wire op_ok_hi = (byte_in[7:4] == `SPE_OP_HIGH_NIB);
    wire is_read  = op_ok_hi & (byte_in[2:0] == `SPE_OP_READ_LOW);
    wire is_write = op_ok_hi & (byte_in[2:0] == `SPE_OP_WRITE_LOW);
    wire [7:0] status = busy ? `SPE_STAT_BUSY :
                        {`SPE_STAT_TOP, bp, wlatch, 1'b0};
    wire start_prog = cs_rise & (st_pend | (pvalid != 0)) & wp_s;

    // serial command engine
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state      <= ST_IDLE;
            bitc       <= 3'h0;
            shin       <= 8'h00;
            opcode     <= 8'h00;
            addr       <= {AW{1'b0}};
            wlatch     <= 1'b0;
            bp         <= `SPE_BP_NONE;
            bp_pend    <= `SPE_BP_NONE;
            st_pend    <= 1'b0;
            latch_pend <= 1'b0;
            pvalid     <= {`SPE_PAGE_BYTES{1'b0}};
            page_base  <= {AW{1'b0}};
        end else if (!sel) begin
            state <= ST_IDLE;
            bitc  <= 3'h0;
            if (cs_rise && latch_pend && !busy) begin
                wlatch <= 1'b1;
            end
            if (start_prog) begin
                if (st_pend) begin
                    bp <= bp_pend;
                end
                wlatch <= 1'b0;
            end
            if (cs_rise && !start_prog) begin
                pvalid <= {`SPE_PAGE_BYTES{1'b0}};
            end
            st_pend    <= 1'b0;
            latch_pend <= 1'b0;
            // drop the page only after the flush has visited every entry
            if (prog && &pidx) begin
                pvalid <= {`SPE_PAGE_BYTES{1'b0}};
            end
        end else begin
            if (state == ST_IDLE) begin
                state <= ST_OP;
            end
            if (!wp_s) begin
                st_pend <= 1'b0;
            end
            // a running flush is not disturbed by the guard pin
            if ((!wp_s && !prog) || (prog && &pidx)) begin
                pvalid  <= {`SPE_PAGE_BYTES{1'b0}};
            end
            if (sck_rise && state != ST_IDLE) begin
                shin <= byte_in;
                bitc <= bitc + 3'h1;
                latch_pend <= 1'b0;
                if (last_bit) begin
                    case (state)
                        ST_OP: begin
                            opcode <= byte_in;
                            state  <= ST_SKIP;
                            if (byte_in == `SPE_OP_STAT_READ) begin
                                state <= ST_RDAT;
                            end else if (busy) begin
                                state <= ST_SKIP;
                            end else if (byte_in == `SPE_OP_SET_LATCH) begin
                                latch_pend <= 1'b1;
                            end else if (byte_in == `SPE_OP_CLR_LATCH) begin
                                wlatch <= 1'b0;
                            end else if (byte_in == `SPE_OP_STAT_WRITE) begin
                                state <= ST_WDAT;
                            end else if (is_read | is_write) begin
                                state <= ST_ADDR;
                                addr[AW-1] <= byte_in[`SPE_OP_A8_BIT];
                            end
                        end
                        ST_ADDR: begin
                            addr[7:0] <= byte_in;
                            page_base <= {addr[AW-1], byte_in[7:PB],
                                          {PB{1'b0}}};
                            state <= (opcode[2:0] == `SPE_OP_READ_LOW)
                                     ? ST_RDAT : ST_WDAT;
                        end
                        ST_WDAT: begin
                            if (opcode == `SPE_OP_STAT_WRITE) begin
                                if (wlatch && wp_s) begin
                                    bp_pend <= byte_in[3:2];
                                    st_pend <= 1'b1;
                                end
                                state <= ST_SKIP;
                            end else begin
                                if (wlatch && wp_s &&
                                    !prot(bp, addr)) begin
                                    pbuf[addr[PB-1:0]]   <= byte_in;
                                    pvalid[addr[PB-1:0]] <= 1'b1;
                                end
                                addr[PB-1:0] <= addr[PB-1:0] + 1'b1;
                            end
                        end
                        ST_RDAT: begin
                            if (opcode != `SPE_OP_STAT_READ) begin
                                addr <= addr + 1'b1;
                            end
                        end
                        default: state <= ST_SKIP;
                    endcase
                end
            end
        end
    end

    // self-timed programming: flush page buffer, then hold busy
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prog   <= 1'b0;
            pidx   <= {PB{1'b0}};
            wtimer <= 32'h0;
        end else if (start_prog && !busy) begin
            prog   <= 1'b1;
            pidx   <= {PB{1'b0}};
            wtimer <= WC_TIME;
        end else begin
            if (prog) begin
                pidx <= pidx + 1'b1;
                if (&pidx) begin
                    prog <= 1'b0;
                end
            end
            if (wtimer != 32'h0) begin
                wtimer <= wtimer - 32'h1;
            end
        end
    end

    wire          mem_we = prog & pvalid[pidx];
    wire [AW-1:0] mem_wa = page_base | {{(AW-PB){1'b0}}, pidx};

    spe_mem #(.AW(AW)) u_mem (
        .core_clk (core_clk),
        .wr_en    (mem_we),
        .wr_addr  (mem_wa),
        .wr_data  (pbuf[pidx]),
        .rd_addr  (addr),
        .rd_data  (mem_rd)
    );

    // output shifter, loads at byte boundary, shifts on falling sck
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            shout  <= 8'h00;
            out_en <= 1'b0;
            so     <= 1'b0;
            so_oe  <= 1'b0;
        end else if (!sel) begin
            out_en <= 1'b0;
            so_oe  <= 1'b0;
        end else begin
            if (sck_fall && state == ST_RDAT) begin
                if (bitc == 3'h0) begin
                    shout <= {((opcode == `SPE_OP_STAT_READ) ? status[6:0]
                              : mem_rd[6:0]), 1'b0};
                    so    <= (opcode == `SPE_OP_STAT_READ) ? status[7]
                             : mem_rd[7];
                end else begin
                    so    <= shout[7];
                    shout <= {shout[6:0], 1'b0};
                end
                out_en <= 1'b1;
            end
            so_oe <= out_en & ~paused & (state == ST_RDAT) |
                     (sck_fall & state == ST_RDAT & ~paused);
        end
    end
endmodule

// >>> spe_chk_asserts.sv
// concurrent checks on the serial eeprom core pins
`timescale 1ns/1ns
module spe_chk #(
    parameter int WC_TIME = 3000
) (
    // clock and reset
    input logic core_clk,
    input logic arst_n,
    // spi pins
    input logic cs_n,
    input logic sck,
    input logic si,
    input logic hold_n,
    input logic wp_n,
    input logic so,
    input logic so_oe,
    // state
    input logic busy
);
    logic [31:0] busy_len;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n)
            busy_len <= 32'h0;
        else
            busy_len <= busy ? busy_len + 32'h1 : 32'h0;
    end
    chk_cs_float: assert property (cs_n [*6] |-> !so_oe)
        else $error("so driven while deselected");
    chk_hold_float: assert property ((!hold_n) [*6] |-> !so_oe)
        else $error("so driven during pause");
    chk_oe_cause: assert property ($rose(so_oe) |-> !cs_n && !sck)
        else $error("so enabled outside a data slot");
    chk_so_edge: assert property (so_oe && $changed(so) |-> !sck)
        else $error("so moved while sck high");
    chk_op_quiet: assert property ($fell(cs_n) |-> !so_oe [*8])
        else $error("so driven during opcode");
    chk_busy_start: assert property ($rose(busy) |-> cs_n)
        else $error("write cycle began while selected");
    chk_guard_block: assert property ($rose(busy) |-> $past(wp_n, 8))
        else $error("write cycle began with guard low");
    chk_busy_time: assert property ($fell(busy) |->
        busy_len >= WC_TIME - 2 && busy_len <= WC_TIME + 2)
        else $error("write cycle length wrong");
endmodule
bind spe_core spe_chk #(.WC_TIME(WC_TIME)) u_chk (
    .core_clk(core_clk), .arst_n(arst_n), .cs_n(cs_n), .sck(sck),
    .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe),
    .busy(busy)
);

// >>> spe_host.sv
// host spi master model driving the serial eeprom pins
`timescale 1ns/1ns
module spe_host (
    // clock
    input  logic core_clk,
    // spi pins
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic hold_n,
    input  logic so,
    input  logic so_oe
);
    logic seen_oe;
    wire  so_w;
    // a floating so reads back as the inverse of the held value
    assign so_w = so_oe ? so : ~so;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
        seen_oe = 1'b0;
    end
    task half;
        repeat (20) @(negedge core_clk);
    endtask
    task sel;
        seen_oe = 1'b0;
        cs_n = 1'b0;
        half;
    endtask
    task desel;
        half;
        cs_n = 1'b1;
        si = ~si;
        half;
    endtask
    task xfer(input logic [7:0] t, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            si = t[i];
            half;
            sck = 1'b1;
            r[i] = so_w;
            seen_oe = seen_oe | so_oe;
            half;
            sck = 1'b0;
        end
    endtask
    task pause(output logic oe);
        hold_n = 1'b0;
        si = ~si;
        half;
        oe = so_oe;
        hold_n = 1'b1;
        half;
    endtask
endmodule

// >>> tb_spe_core.sv
// self-checking bench for the serial eeprom command core
`timescale 1ns/1ns
module tb_spe_core;
    localparam int WC = 3000;
    logic       core_clk;
    logic       arst_n;
    logic       wp_n;
    logic       oe;
    logic [7:0] rx;
    logic [7:0] st;
    logic [8:0] a;
    wire        cs_n, sck, si, hold_n, so, so_oe, busy;
    int         mismatches;
    int         checks;
    spe_core #(.AW(9), .WC_TIME(WC)) u_dut (
        .core_clk(core_clk), .arst_n(arst_n), .cs_n(cs_n), .sck(sck),
        .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe),
        .busy(busy)
    );
    spe_host u_host (
        .core_clk(core_clk), .cs_n(cs_n), .sck(sck), .si(si),
        .hold_n(hold_n), .so(so), .so_oe(so_oe)
    );
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task ck(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task cmd(input logic [7:0] op);
        u_host.sel;
        u_host.xfer(op, rx);
        u_host.desel;
    endtask
    task op2(input logic [7:0] op, input logic [7:0] b, output logic [7:0] r);
        u_host.sel;
        u_host.xfer(op, rx);
        u_host.xfer(b, r);
    endtask
    task status_read_command;
        op2(8'h05, 8'h00, st);
        u_host.desel;
    endtask
    task wsr(input logic [7:0] v);
        cmd(8'h06);
        op2(8'h01, v, rx);
        u_host.desel;
    endtask
    task wait_ready;
        for (int i = 0; i < 20; i++) begin
            status_read_command;
            if (st[0] === 1'b0)
                return;
        end
        mismatches++;
        $display("BAD %0t write cycle never ended", $time);
        finish_test;
    endtask
    task wr(input logic [8:0] ad, input int n, input logic [23:0] d);
        cmd(8'h06);
        op2({4'h0, ad[8], 3'h2}, ad[7:0], rx);
        for (int k = 0; k < n; k++)
            u_host.xfer(d[23-8*k -: 8], rx);
        u_host.desel;
    endtask
    initial begin
        mismatches = 0;
        checks = 0;
        wp_n = 1'b1;
        arst_n = 1'b0;
        repeat (3) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        status_read_command;
        ck(st, 8'hf0);
        cmd(8'h06);
        status_read_command;
        ck(st, 8'hf2);
        cmd(8'h04);
        status_read_command;
        ck(st, 8'hf0);
        op2(8'h06, 8'h00, rx);
        u_host.desel;
        status_read_command;
        ck(st, 8'hf0);
        op2(8'h02, 8'h10, rx);
        u_host.xfer(8'h55, rx);
        u_host.desel;
        ck({7'h0, busy}, 8'h00);
        $display("test latch done");
        wp_n = 1'b0;
        wsr(8'h0c);
        ck({7'h0, busy}, 8'h00);
        wp_n = 1'b1;
        cmd(8'h06);
        op2(8'h01, 8'h0c, rx);
        wp_n = 1'b0;
        u_host.desel;
        ck({7'h0, busy}, 8'h00);
        wp_n = 1'b1;
        status_read_command;
        ck(st & 8'hfc, 8'hf0);
        $display("test guard done");
        wsr(8'h07);
        ck({7'h0, busy}, 8'h01);
        status_read_command;
        ck(st, 8'hff);
        op2(8'h03, 8'h00, rx);
        u_host.xfer(8'h00, rx);
        u_host.desel;
        ck({7'h0, u_host.seen_oe}, 8'h00);
        wait_ready;
        ck(st, 8'hf4);
        wsr(8'h00);
        wait_ready;
        $display("test status done");
        wr(9'h1ff, 1, 24'h5a0000);
        wait_ready;
        wr(9'h0fe, 3, 24'ha1a2a3);
        wait_ready;
        wr(9'h000, 1, 24'hc30000);
        wait_ready;
        ck(st, 8'hf0);
        op2(8'h0b, 8'hff, rx);
        u_host.xfer(8'h00, rx);
        ck(rx, 8'h5a);
        u_host.xfer(8'h00, rx);
        ck(rx, 8'hc3);
        u_host.desel;
        op2(8'h03, 8'hfe, rx);
        u_host.xfer(8'h00, rx);
        ck(rx, 8'ha1);
        u_host.pause(oe);
        ck({7'h0, oe}, 8'h00);
        u_host.xfer(8'h00, rx);
        ck(rx, 8'ha2);
        u_host.desel;
        op2(8'h03, 8'hf0, rx);
        u_host.xfer(8'h00, rx);
        ck(rx, 8'ha3);
        u_host.desel;
        $display("test array done");
        for (int m = 1; m < 4; m++) begin
            wsr({4'h0, m[1:0], 2'h0});
            wait_ready;
            ck(st, {4'hf, m[1:0], 2'h0});
            a = (m == 1) ? 9'h180 : (m == 2) ? 9'h100 : 9'h000;
            wr(a, 1, 24'h0);
            ck({7'h0, busy}, 8'h00);
            if (m < 3) begin
                wr(a - 9'h1, 1, 24'h0);
                ck({7'h0, busy}, 8'h01);
                wait_ready;
            end
        end
        $display("test protect done");
        op2(8'hff, 8'h00, rx);
        u_host.xfer(8'h00, rx);
        u_host.desel;
        ck({7'h0, u_host.seen_oe}, 8'h00);
        $display("test opcode done");
        finish_test;
    end
endmodule
